// ### logic/monitor_bank_pkg.sv
package monitor_bank_pkg;

  // Register offsets on the serial control port.
  localparam logic [6:0] OFS_DETECTION_FLAGS = 7'h1e;
  localparam logic [6:0] OFS_HOLD_LEVEL      = 7'h1f;
  localparam logic [6:0] OFS_CMP_DRIFT       = 7'h20;
  localparam logic [6:0] OFS_CMP_AVERAGE     = 7'h21;
  localparam logic [6:0] OFS_SIGNAL_STRENGTH = 7'h22;
  localparam logic [6:0] OFS_NOISE_LEVEL     = 7'h23;

  // Bit positions in the detection flags register.
  localparam int BIT_SYNTH_LOCKED   = 7;
  localparam int BIT_STRENGTH_DET   = 6;
  localparam int BIT_NOISE_DETECTED_FLAG      = 5;
  localparam int BIT_PREAMBLE_FOUND = 4;
  localparam logic [3:0] UNUSED_FLAGS_VALUE = 4'h0;

  // Values forced onto monitors whose source is off or saturated.
  localparam logic [7:0] MONITOR_OFF_VALUE = 8'h00;
  localparam logic [7:0] MONITOR_SAT_VALUE = 8'hff;
  localparam logic [7:0] UNMAPPED_VALUE    = 8'h00;

  // Drift scale: one count is 1/1.53 kHz, so the limit in counts follows.
  localparam real DRIFT_LIMIT_KHZ     = 165.75;
  localparam real DRIFT_COUNTS_PER_KHZ = 1.53;
  localparam logic [9:0] DRIFT_LIMIT_CNT =
    10'(int'($floor(DRIFT_LIMIT_KHZ * DRIFT_COUNTS_PER_KHZ)));

  // Serial frame: command byte (read flag + address), then one data byte.
  localparam int         READ_FLAG_BIT = 7;
  localparam logic [2:0] LAST_BIT_CNT  = 3'h7;
  localparam logic [2:0] FIRST_BIT_CNT = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } serial_state_e;

endpackage

// ### logic/pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the output moves once stages two and three agree.
module pin_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      level_out
);

  logic [2:0] stage_reg;

  // Stage one feeds stage two only; the filter compares two and three.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage_reg <= {3{RESET_VALUE}};
      level_out <= RESET_VALUE;
    end else begin
      stage_reg <= {stage_reg[1:0], pin_in};
      if (stage_reg[1] == stage_reg[2]) begin
        level_out <= stage_reg[2];
      end
    end
  end

endmodule

// ### logic/receiver_status_monitor_bank.sv
`timescale 1ns/1ps
//
// Function
// RULE1 - Top bit of the detection flags reads 1 when locked, 0 when not.
// RULE2 - Flag bits 6 to 4 mirror the strength, noise and preamble detects.
// RULE3 - The four low bits of the detection flags always read zero.
// RULE4 - The hold level monitor shows the 8-bit amplitude-hold value.
// RULE5 - The hold level monitor reads zero under frequency-shift demod.
// RULE6 - In amplitude mode the hold value excludes quick charge 2.
// RULE7 - The drift monitor shows an 8-bit drift count of 1/1.53 kHz each.
// RULE8 - The drift monitor holds all ones once drift passes 165.75 kHz.
// RULE9 - Drift and average monitors read zero while digital logic is off.
// RULE10 - The average monitor shows the 8-bit average comparator reference.
// RULE11 - The strength monitor shows the strength level, or zero when off.
// RULE12 - The noise monitor shows the noise level, or zero when off.
// RULE13 - All six monitors are read-only and writes leave them untouched.
//
module receiver_status_monitor_bank (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  input  wire logic       synth_lock_in,
  input  wire logic       strength_detect_output,
  input  wire logic       noise_detect_output,
  input  wire logic       preamble_detect_output,
  input  wire logic       fsk_mode,
  input  wire logic       digital_enable,
  input  wire logic       strength_enable,
  input  wire logic       noise_enable,
  input  wire logic [7:0] hold_level_value,
  input  wire logic [9:0] comparator_drift_value,
  input  wire logic [7:0] comparator_average_value,
  input  wire logic [7:0] signal_strength_value,
  input  wire logic [7:0] noise_level_value
);

  typedef struct packed {
    monitor_bank_pkg::serial_state_e state;
    logic       sclk_prev;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic       is_read;
    logic       miso;
    logic       miso_oe;
    logic [7:0] detection_flags;
    logic [7:0] hold_level_monitor;
    logic [7:0] comparator_drift_monitor;
    logic [7:0] comparator_average_monitor;
    logic [7:0] signal_strength_monitor;
    logic [7:0] noise_level_monitor;
  } bank_state_s;

  bank_state_s state_reg;
  bank_state_s state_next;

  logic       cs_n_sync;
  logic       sclk_sync;
  logic       mosi_sync;
  logic       lock_sync;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [7:0] cmd_byte;

  // Pins and the lock level come from outside this clock.
  pin_sync #(.RESET_VALUE(1'b1)) cs_sync_u (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (cs_n),
    .level_out (cs_n_sync)
  );

  pin_sync #(.RESET_VALUE(1'b0)) sclk_sync_u (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (sclk),
    .level_out (sclk_sync)
  );

  pin_sync #(.RESET_VALUE(1'b0)) mosi_sync_u (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (mosi),
    .level_out (mosi_sync)
  );

  pin_sync #(.RESET_VALUE(1'b0)) lock_sync_u (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (synth_lock_in),
    .level_out (lock_sync)
  );

  // Clamps a wide drift count to eight bits instead of letting it wrap.
  function automatic logic [7:0] clamp_drift(input logic [9:0] raw);
    if (raw > monitor_bank_pkg::DRIFT_LIMIT_CNT) begin
      clamp_drift = monitor_bank_pkg::MONITOR_SAT_VALUE;
    end else begin
      clamp_drift = raw[7:0];
    end
  endfunction

  // Forces a monitor to zero when its source circuit is off.
  function automatic logic [7:0] gate_value(input logic on,
                                            input logic [7:0] value);
    gate_value = on ? value : monitor_bank_pkg::MONITOR_OFF_VALUE;
  endfunction

  // Read mux over the six monitors; other addresses read zero.
  function automatic logic [7:0] read_mux(input logic [6:0] addr,
                                          input bank_state_s s);
    case (addr)
      monitor_bank_pkg::OFS_DETECTION_FLAGS: read_mux = s.detection_flags;
      monitor_bank_pkg::OFS_HOLD_LEVEL:      read_mux = s.hold_level_monitor;
      monitor_bank_pkg::OFS_CMP_DRIFT:
        read_mux = s.comparator_drift_monitor;
      monitor_bank_pkg::OFS_CMP_AVERAGE:
        read_mux = s.comparator_average_monitor;
      monitor_bank_pkg::OFS_SIGNAL_STRENGTH:
        read_mux = s.signal_strength_monitor;
      monitor_bank_pkg::OFS_NOISE_LEVEL:     read_mux = s.noise_level_monitor;
      default:                               read_mux =
        monitor_bank_pkg::UNMAPPED_VALUE;
    endcase
  endfunction

  // Edges of the filtered serial clock.
  assign sclk_rise = sclk_sync & ~state_reg.sclk_prev;
  assign sclk_fall = ~sclk_sync & state_reg.sclk_prev;
  assign cmd_byte  = {state_reg.shift_in[6:0], mosi_sync};

  // Next state: monitor sampling every cycle plus the serial port machine.
  always_comb begin
    state_next = state_reg;
    state_next.sclk_prev = sclk_sync;

    state_next.detection_flags = {
      lock_sync,                                   // RULE1
      strength_detect_output,                      // RULE2
      noise_detect_output,                         // RULE2
      preamble_detect_output,                      // RULE2
      monitor_bank_pkg::UNUSED_FLAGS_VALUE};       // RULE3
    // The raw hold input is the level without quick charge 2 applied.
    state_next.hold_level_monitor =
      gate_value(~fsk_mode, hold_level_value);     // RULE4 RULE5 RULE6
    state_next.comparator_drift_monitor =
      gate_value(digital_enable,
                 clamp_drift(comparator_drift_value)); // RULE7 RULE8 RULE9
    state_next.comparator_average_monitor =
      gate_value(digital_enable, comparator_average_value); // RULE9 RULE10
    state_next.signal_strength_monitor =
      gate_value(strength_enable, signal_strength_value); // RULE11
    state_next.noise_level_monitor =
      gate_value(noise_enable, noise_level_value); // RULE12

    if (cs_n_sync) begin
      state_next.state   = monitor_bank_pkg::ST_IDLE;
      state_next.bit_cnt = monitor_bank_pkg::FIRST_BIT_CNT;
      state_next.miso    = 1'b0;
      state_next.miso_oe = 1'b0;
      state_next.is_read = 1'b0;
    end else begin
      case (state_reg.state)
        monitor_bank_pkg::ST_IDLE: begin
          state_next.state   = monitor_bank_pkg::ST_ADDR;
          state_next.bit_cnt = monitor_bank_pkg::FIRST_BIT_CNT;
        end
        monitor_bank_pkg::ST_ADDR: begin
          if (sclk_fall) begin
            // Release the line and park the data bit low during the command byte.
            state_next.miso_oe = 1'b0;
            state_next.miso    = 1'b0;
          end
          if (sclk_rise) begin
            state_next.shift_in = cmd_byte;
            state_next.bit_cnt  = state_reg.bit_cnt + 3'h1;
            if (state_reg.bit_cnt == monitor_bank_pkg::LAST_BIT_CNT) begin
              state_next.is_read   = cmd_byte[monitor_bank_pkg::READ_FLAG_BIT];
              state_next.shift_out = read_mux(cmd_byte[6:0], state_reg);
              state_next.state     = monitor_bank_pkg::ST_DATA;
            end
          end
        end
        monitor_bank_pkg::ST_DATA: begin
          // Write data is shifted in and dropped; no monitor changes.
          if (sclk_fall && state_reg.is_read) begin
            state_next.miso_oe   = 1'b1;
            state_next.miso      = state_reg.shift_out[7];
            state_next.shift_out = {state_reg.shift_out[6:0], 1'b0};
          end
          if (sclk_rise) begin
            state_next.shift_in = cmd_byte; // RULE13
            state_next.bit_cnt  = state_reg.bit_cnt + 3'h1;
            if (state_reg.bit_cnt == monitor_bank_pkg::LAST_BIT_CNT) begin
              state_next.state   = monitor_bank_pkg::ST_ADDR;
              state_next.is_read = 1'b0;
            end
          end
        end
        default: begin
          state_next.state = monitor_bank_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // All state in one register; the monitors start at zero.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Serial data out comes straight from the state register.
  assign miso    = state_reg.miso;
  assign miso_oe = state_reg.miso_oe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Lock flag follows the synchronised lock level one cycle later.
  lock_flag_a: assert property (1'b1 |=> // RULE1
    state_reg.detection_flags[monitor_bank_pkg::BIT_SYNTH_LOCKED]
      == $past(lock_sync))
    else $error("lock flag does not follow lock level");

  // Detect flags mirror the three detect outputs.
  detect_flags_a: assert property (1'b1 |=> // RULE2
    state_reg.detection_flags[monitor_bank_pkg::BIT_STRENGTH_DET:
                              monitor_bank_pkg::BIT_PREAMBLE_FOUND]
      == $past({strength_detect_output,
      noise_detect_output, preamble_detect_output}))
    else $error("detect flags do not follow detect outputs");

  // Low flag bits never carry anything.
  unused_bits_a: assert property ( // RULE3
    state_reg.detection_flags[3:0] == monitor_bank_pkg::UNUSED_FLAGS_VALUE)
    else $error("unused flag bits not zero");

  // Hold monitor passes the level in amplitude mode and is zero otherwise.
  hold_pass_a: assert property (!fsk_mode |=> // RULE4
    state_reg.hold_level_monitor == $past(hold_level_value))
    else $error("hold level not passed in amplitude mode");

  hold_fsk_a: assert property (fsk_mode |=> // RULE5
    state_reg.hold_level_monitor == monitor_bank_pkg::MONITOR_OFF_VALUE)
    else $error("hold level not zero in frequency mode");

  // Drift counts pass up to the limit and saturate above it.
  drift_pass_a: assert property ( // RULE7
    digital_enable &&
    comparator_drift_value <= monitor_bank_pkg::DRIFT_LIMIT_CNT |=>
    state_reg.comparator_drift_monitor == $past(comparator_drift_value[7:0]))
    else $error("drift count not passed through");

  drift_sat_a: assert property ( // RULE8
    digital_enable &&
    comparator_drift_value > monitor_bank_pkg::DRIFT_LIMIT_CNT |=>
    state_reg.comparator_drift_monitor == monitor_bank_pkg::MONITOR_SAT_VALUE)
    else $error("drift monitor wrapped instead of saturating");

  // Both comparator monitors read zero while the digital logic is off.
  digital_off_a: assert property (!digital_enable |=> // RULE9
    state_reg.comparator_drift_monitor == monitor_bank_pkg::MONITOR_OFF_VALUE
    && state_reg.comparator_average_monitor ==
       monitor_bank_pkg::MONITOR_OFF_VALUE)
    else $error("comparator monitors not zero while off");

  // Average value passes while the digital logic runs.
  average_pass_a: assert property (digital_enable |=> // RULE10
    state_reg.comparator_average_monitor == $past(comparator_average_value))
    else $error("average value not passed through");

  // Strength and noise monitors follow their level or read zero when off.
  strength_gate_a: assert property (1'b1 |=> // RULE11
    state_reg.signal_strength_monitor ==
      ($past(strength_enable) ? $past(signal_strength_value)
                              : monitor_bank_pkg::MONITOR_OFF_VALUE))
    else $error("strength monitor wrong");

  noise_gate_a: assert property (1'b1 |=> // RULE12
    state_reg.noise_level_monitor ==
      ($past(noise_enable) ? $past(noise_level_value)
                           : monitor_bank_pkg::MONITOR_OFF_VALUE))
    else $error("noise monitor wrong");

  // A write frame never drives the data line.
  write_quiet_a: assert property ( // RULE13
    state_reg.state == monitor_bank_pkg::ST_DATA && !state_reg.is_read
      |-> !state_reg.miso_oe)
    else $error("output driven during a write");

  // Nothing is driven while the chip is not selected.
  deselect_a: assert property (cs_n_sync |=> !miso_oe && !miso)
    else $error("output driven while deselected");

  // Main scenarios: read, write, saturation, lock and frequency mode.
  read_frame_c: cover property (state_reg.state == monitor_bank_pkg::ST_DATA
    && state_reg.is_read && sclk_rise
    && state_reg.bit_cnt == monitor_bank_pkg::LAST_BIT_CNT);
  write_frame_c: cover property (state_reg.state == monitor_bank_pkg::ST_DATA
    && !state_reg.is_read && sclk_rise);
  drift_sat_c: cover property (state_reg.comparator_drift_monitor
    == monitor_bank_pkg::MONITOR_SAT_VALUE);
  locked_c: cover property (
    state_reg.detection_flags[monitor_bank_pkg::BIT_SYNTH_LOCKED]);
  fsk_zero_c: cover property (fsk_mode
    && hold_level_value != monitor_bank_pkg::MONITOR_OFF_VALUE);

endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
// Compares two values, counts the compare and reports a mismatch at once.
`define CHECK_EQ(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("unexpected at %0t: got %h want %h", $time, got, exp); \
    end \
  end

module tb;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       cs_n = 1'b1;
  logic       sclk = 1'b0;
  logic       mosi = 1'b0;
  logic       miso;
  logic       miso_oe;
  logic       synth_lock_in = 1'b0;
  logic       strength_det = 1'b0;
  logic       noise_detected_flag = 1'b0;
  logic       preamble_det = 1'b0;
  logic       fsk_mode = 1'b0;
  logic       digital_enable = 1'b1;
  logic       strength_enable = 1'b1;
  logic       noise_enable = 1'b1;
  logic [7:0] hold_value = 8'h00;
  logic [9:0] drift_value = 10'h000;
  logic [7:0] average_value = 8'h00;
  logic [7:0] strength_value = 8'h00;
  logic [7:0] noise_value = 8'h00;
  logic [7:0] rd_data;
  logic       rd_oe;
  int         n_errors = 0;
  int         num_checks = 0;
  int         cycles = 0;

  receiver_status_monitor_bank u_dut (
    .clk_sys                  (clk_sys),
    .reset                    (reset),
    .cs_n                     (cs_n),
    .sclk                     (sclk),
    .mosi                     (mosi),
    .miso                     (miso),
    .miso_oe                  (miso_oe),
    .synth_lock_in            (synth_lock_in),
    .strength_detect_output   (strength_det),
    .noise_detect_output      (noise_detected_flag),
    .preamble_detect_output   (preamble_det),
    .fsk_mode                 (fsk_mode),
    .digital_enable           (digital_enable),
    .strength_enable          (strength_enable),
    .noise_enable             (noise_enable),
    .hold_level_value         (hold_value),
    .comparator_drift_value   (drift_value),
    .comparator_average_value (average_value),
    .signal_strength_value    (strength_value),
    .noise_level_value        (noise_value)
  );

  // The 10 MHz system clock.
  always #50 clk_sys = ~clk_sys;

  // Prints the verdict and ends the run.
  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hung run short; a full run needs about 4200 cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // Waits a number of falling clock edges, where all inputs change.
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Shifts one byte MSB first; the reply is sampled before each rising sclk.
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx,
                           output logic oe_any);
    oe_any = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      wait_n(6);
      rx[i] = miso;
      oe_any = oe_any | miso_oe;
      sclk = 1'b1;
      wait_n(6);
      sclk = 1'b0;
    end
  endtask

  // One framed transfer: command byte, then the data byte.
  task automatic frame(input logic rd, input logic [6:0] addr,
                       input logic [7:0] wdata, output logic [7:0] rdata,
                       output logic oe);
    logic [7:0] dummy;
    logic       cmd_oe;
    cs_n = 1'b0;
    wait_n(6);
    xfer_byte({rd, addr}, dummy, cmd_oe);
    xfer_byte(wdata, rdata, oe);
    wait_n(6);
    cs_n = 1'b1;
    wait_n(10);
  endtask

  // Reads a register and compares it with the expected value.
  task automatic check_reg(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       oe;
    wait_n(8);
    frame(1'b1, addr, 8'h00, d, oe);
    `CHECK_EQ(oe, 1'b1)
    `CHECK_EQ(d, exp)
  endtask

  // Main sequence of register reads and writes.
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    wait_n(6);
    synth_lock_in = 1'b1;
    strength_det = 1'b1;
    preamble_det = 1'b1;
    check_reg(monitor_bank_pkg::OFS_DETECTION_FLAGS, 8'hd0);
    synth_lock_in = 1'b0;
    strength_det = 1'b0;
    noise_detected_flag = 1'b1;
    preamble_det = 1'b0;
    check_reg(monitor_bank_pkg::OFS_DETECTION_FLAGS, 8'h20);
    noise_detected_flag = 1'b0;
    check_reg(monitor_bank_pkg::OFS_DETECTION_FLAGS, 8'h00);
    hold_value = 8'h5a;
    check_reg(monitor_bank_pkg::OFS_HOLD_LEVEL, 8'h5a);
    fsk_mode = 1'b1;
    check_reg(monitor_bank_pkg::OFS_HOLD_LEVEL, 8'h00);
    drift_value = 10'h064;
    check_reg(monitor_bank_pkg::OFS_CMP_DRIFT, 8'h64);
    drift_value = 10'h0fd;
    check_reg(monitor_bank_pkg::OFS_CMP_DRIFT, 8'hfd);
    drift_value = 10'h0fe;
    check_reg(monitor_bank_pkg::OFS_CMP_DRIFT, 8'hff);
    drift_value = 10'h3ff;
    check_reg(monitor_bank_pkg::OFS_CMP_DRIFT, 8'hff);
    average_value = 8'ha5;
    check_reg(monitor_bank_pkg::OFS_CMP_AVERAGE, 8'ha5);
    digital_enable = 1'b0;
    check_reg(monitor_bank_pkg::OFS_CMP_DRIFT, 8'h00);
    check_reg(monitor_bank_pkg::OFS_CMP_AVERAGE, 8'h00);
    strength_value = 8'h3c;
    check_reg(monitor_bank_pkg::OFS_SIGNAL_STRENGTH, 8'h3c);
    strength_enable = 1'b0;
    check_reg(monitor_bank_pkg::OFS_SIGNAL_STRENGTH, 8'h00);
    noise_value = 8'hc3;
    check_reg(monitor_bank_pkg::OFS_NOISE_LEVEL, 8'hc3);
    noise_enable = 1'b0;
    check_reg(monitor_bank_pkg::OFS_NOISE_LEVEL, 8'h00);
    strength_enable = 1'b1;
    frame(1'b0, monitor_bank_pkg::OFS_SIGNAL_STRENGTH, 8'hff, rd_data, rd_oe);
    `CHECK_EQ(rd_oe, 1'b0)
    check_reg(monitor_bank_pkg::OFS_SIGNAL_STRENGTH, 8'h3c);
    check_reg(7'h24, 8'h00);
    end_sim();
  end
endmodule
